// >>> tb.sv
/*
 * Self-checking testbench of the serial unit register bank.
 * Assumes the design and its bound checker are compiled before it.
 */
`timescale 1ns/100ps

module tb;
	logic                     clock;
	logic                     rst_b;
	urb_pkg::urb_bus_req_type req;
	logic                     protect_on;
	logic [7:0]               irq_event;
	logic [7:0]               status_event;
	logic                     cts_level;
	logic [8:0]               rx_char;
	logic [31:0]              bus_rdata;
	logic                     bus_error;
	logic                     bus_done;
	logic                     unit_enabled;
	logic                     irq_line;
	urb_pkg::urb_cfg_type     cfg;
	logic [8:0]               tx_char;
	logic                     tx_char_valid;
	int                       n_errors;
	int                       n_compared;
	localparam logic [31:0]   FIELDS = urb_pkg::CONTROL_A_MASK & 32'hFFFFFFFC;

	urb_register_bank urb_register_bank_inst (
		.clock         (clock),
		.rst_b         (rst_b),
		.bus_req       (req),
		.protect_on    (protect_on),
		.irq_event     (irq_event),
		.status_event  (status_event),
		.cts_level     (cts_level),
		.rx_char       (rx_char),
		.bus_rdata     (bus_rdata),
		.bus_error     (bus_error),
		.bus_done      (bus_done),
		.cfg           (cfg),
		.unit_enabled  (unit_enabled),
		.irq_line      (irq_line),
		.tx_char       (tx_char),
		.tx_char_valid (tx_char_valid),
		.rx_char_taken ()
	);

	// ------------------------------------------------------------------
	// Clock, closing and shared tasks
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic results();
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One request held for one edge, answer taken in the next cycle
	task automatic acc(input logic w, input logic [1:0] sz,
		input logic [5:0] a, input logic [31:0] d, input logic eerr);
		@(negedge clock);
		req = '{sel: 1'b1, write: w, size: sz, addr: a, wdata: d};
		@(negedge clock);
		req.sel = 1'b0;
		chk({31'h0, bus_done}, 32'h1);
		chk({31'h0, bus_error}, {31'h0, eerr});
	endtask

	task automatic wr(input logic [1:0] sz, input logic [5:0] a,
		input logic [31:0] d, input logic eerr);
		acc(1'b1, sz, a, d, eerr);
	endtask

	task automatic rd(input logic [1:0] sz, input logic [5:0] a,
		input logic [31:0] exp);
		acc(1'b0, sz, a, 32'h00000000, 1'b0);
		chk(bus_rdata, exp);
	endtask

	task automatic settle();
		repeat (urb_pkg::SYNC_CYCLES + 3) @(negedge clock);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_map();
		rd(urb_pkg::SIZE_WORD, 6'h00, 32'h00000000);
		wr(urb_pkg::SIZE_BYTE, 6'h09, 32'h0000FF00, 1'b0);
		rd(urb_pkg::SIZE_BYTE, 6'h09, 32'h00000000);
		wr(urb_pkg::SIZE_WORD, 6'h00, 32'hFFFFFFFC, 1'b0);
		rd(urb_pkg::SIZE_WORD, 6'h1C, 32'h00000002);
		wr(urb_pkg::SIZE_BYTE, 6'h00, 32'h00000000, 1'b1);
		settle();
		rd(urb_pkg::SIZE_WORD, 6'h1C, 32'h00000000);
		rd(urb_pkg::SIZE_WORD, 6'h00, FIELDS);
	endtask

	task automatic t_lanes();
		wr(urb_pkg::SIZE_BYTE, 6'h0D, 32'h0000AB00, 1'b0);
		wr(urb_pkg::SIZE_BYTE, 6'h0E, 32'h00CD0000, 1'b0);
		wr(urb_pkg::SIZE_HALF, 6'h0D, 32'h00FFFF00, 1'b1);
		acc(1'b0, urb_pkg::SIZE_WORD, 6'h0E, 32'h0, 1'b1);
		wr(2'h3, 6'h0C, 32'hFFFFFFFF, 1'b1);
		rd(urb_pkg::SIZE_WORD, 6'h0C, 32'h00CDAB00);
		rd(urb_pkg::SIZE_BYTE, 6'h0E, 32'h00CD0000);
		wr(urb_pkg::SIZE_WORD, 6'h04, 32'hFFFFFFFF, 1'b0);
		wr(urb_pkg::SIZE_WORD, 6'h04, 32'h00000000, 1'b1);
		rd(urb_pkg::SIZE_WORD, 6'h04, urb_pkg::CONTROL_B_MASK);
	endtask

	task automatic t_guard();
		protect_on = 1'b1;
		wr(urb_pkg::SIZE_HALF, 6'h0C, 32'h00001111, 1'b1);
		wr(urb_pkg::SIZE_WORD, 6'h04, 32'h00030000, 1'b1);
		protect_on = 1'b0;
		rd(urb_pkg::SIZE_HALF, 6'h0C, 32'h0000AB00);
	endtask

	task automatic t_enable();
		wr(urb_pkg::SIZE_BYTE, 6'h30, 32'h00000001, 1'b0);
		wr(urb_pkg::SIZE_BYTE, 6'h00, 32'h00000002, 1'b0);
		chk({31'h0, unit_enabled}, 32'h0);
		settle();
		chk({31'h0, unit_enabled}, 32'h1);
		chk(cfg.control_b, urb_pkg::CONTROL_B_MASK);
		wr(urb_pkg::SIZE_HALF, 6'h0C, 32'h00005555, 1'b0);
		wr(urb_pkg::SIZE_BYTE, 6'h01, 32'h00000000, 1'b0);
		rd(urb_pkg::SIZE_HALF, 6'h0C, 32'h0000AB00);
		rd(urb_pkg::SIZE_WORD, 6'h00, (FIELDS & 32'hFFFFFF00) | 32'h2);
		wr(urb_pkg::SIZE_BYTE, 6'h00, 32'h00000001, 1'b0);
		settle();
		chk({31'h0, unit_enabled}, 32'h0);
		rd(urb_pkg::SIZE_WORD, 6'h00, 32'h00000000);
		rd(urb_pkg::SIZE_HALF, 6'h0C, 32'h00000000);
		rd(urb_pkg::SIZE_WORD, 6'h04, 32'h00000000);
		rd(urb_pkg::SIZE_BYTE, 6'h30, 32'h00000001);
	endtask

	task automatic t_irq();
		wr(urb_pkg::SIZE_BYTE, 6'h16, 32'h00010000, 1'b0);
		irq_event = 8'h01;
		status_event = 8'h01;
		@(negedge clock);
		irq_event = 8'h00;
		status_event = 8'h00;
		repeat (2) @(negedge clock);
		chk({31'h0, irq_line}, 32'h1);
		rd(urb_pkg::SIZE_BYTE, 6'h14, 32'h00000001);
		wr(urb_pkg::SIZE_BYTE, 6'h14, 32'h00000001, 1'b0);
		repeat (2) @(negedge clock);
		chk({31'h0, irq_line}, 32'h0);
		rd(urb_pkg::SIZE_BYTE, 6'h18, 32'h00000001);
		rd(urb_pkg::SIZE_HALF, 6'h1A, 32'h00090000);
		wr(urb_pkg::SIZE_BYTE, 6'h1A, 32'h00010000, 1'b0);
		rd(urb_pkg::SIZE_HALF, 6'h1A, 32'h00080000);
		rd(urb_pkg::SIZE_HALF, 6'h28, 32'h000001A5);
		wr(urb_pkg::SIZE_HALF, 6'h28, 32'h000001C3, 1'b0);
		chk({23'h0, tx_char}, 32'h000001C3);
		chk({31'h0, tx_char_valid}, 32'h1);
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		n_errors = 0;
		n_compared = 0;
		rst_b = 1'b0;
		req = '0;
		protect_on = 1'b0;
		irq_event = 8'h00;
		status_event = 8'h00;
		cts_level = 1'b1;
		rx_char = 9'h1A5;
		repeat (3) @(posedge clock);
		@(negedge clock);
		rst_b = 1'b1;
		t_map();
		t_lanes();
		t_guard();
		t_enable();
		t_irq();
		results();
	end

	initial begin
		repeat (2000) @(posedge clock);
		n_errors++;
		results();
	end
endmodule

// >>> urb_pkg.sv
/*
 * Package of the serial unit register bank: byte offsets, field masks,
 * reset values, access sizes, the synchronisation delay and the carriers.
 * Assumes a byte-addressed bus whose data sit on the byte lanes of the
 * aligned 32-bit word that holds the addressed byte.
 */
package urb_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [5:0] OFF_CONTROL_A        = 6'h00;
	localparam logic [5:0] OFF_CONTROL_B        = 6'h04;
	localparam logic [5:0] OFF_BAUD_DIVISOR     = 6'h0C;
	localparam logic [5:0] OFF_IRDA_MIN_PULSE   = 6'h0E;
	localparam logic [5:0] OFF_IRQ_ENABLE_CLEAR = 6'h14;
	localparam logic [5:0] OFF_IRQ_ENABLE_SET   = 6'h16;
	localparam logic [5:0] OFF_IRQ_FLAGS        = 6'h18;
	localparam logic [5:0] OFF_LINE_STATUS      = 6'h1A;
	localparam logic [5:0] OFF_SYNC_PENDING     = 6'h1C;
	localparam logic [5:0] OFF_CHAR_DATA        = 6'h28;
	localparam logic [5:0] OFF_DEBUG_CONTROL    = 6'h30;

	// ------------------------------------------------------------------
	// Field masks and bit positions
	// ------------------------------------------------------------------
	localparam logic [31:0] CONTROL_A_MASK  = 32'h7FF3E19F;
	localparam logic [31:0] CONTROL_A_RESET = 32'h00000000;
	localparam logic [31:0] CONTROL_A_LIVE  = 32'h00000003;
	localparam int          SOFT_RESET_BIT  = 0;
	localparam int          ENABLE_BIT      = 1;
	localparam logic [31:0] CONTROL_B_MASK  = 32'h00032747;
	localparam logic [31:0] CONTROL_B_LIVE  = 32'h00030000;
	localparam logic [31:0] CONTROL_B_RESET = 32'h00000000;
	localparam logic [15:0] BAUD_RESET      = 16'h0000;
	localparam logic [7:0]  PULSE_RESET     = 8'h00;
	localparam logic [7:0]  IRQ_MASK        = 8'hBF;
	localparam logic [7:0]  STATUS_W1C_MASK = 8'h37;
	localparam int          CTS_BIT         = 3;
	localparam logic [8:0]  CHAR_RESET      = 9'h000;

	// Indices and number of the busy flags in sync_pending
	localparam int SYNC_SOFT_RESET = 0;
	localparam int SYNC_ENABLE     = 1;
	localparam int SYNC_CONTROL_B  = 2;
	localparam int SYNC_FLAGS      = 3;

	// ------------------------------------------------------------------
	// Access sizes and timing
	// ------------------------------------------------------------------
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam int         SYNC_TIME_NS   = 200;
	localparam int         CLOCK_NS       = 40;
	localparam int         SYNC_CYCLES    = (SYNC_TIME_NS + CLOCK_NS - 1)
		/ CLOCK_NS;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        sel;
		logic        write;
		logic [1:0]  size;
		logic [5:0]  addr;
		logic [31:0] wdata;
	} urb_bus_req_type;

	typedef struct packed {
		logic [31:0] control_a;
		logic [31:0] control_b;
		logic [15:0] baud_divisor;
		logic [7:0]  irda_min_pulse;
		logic        halt_on_debug;
	} urb_cfg_type;

endpackage

// >>> urb_register_bank.sv
/*
 * Register bank of a serial unit run as a USART: control words, baud
 * divisor, infrared pulse length, interrupt enables and flags, status,
 * synchronisation busy, character data and debug control.
 * Assumes a one-cycle request port from the processor side and status
 * events from the serial engine, all on the same clock.
 */
// Contract
// - Byte, halfword and word accesses are taken whole; registers are 8/16/32 bits.
// - Every byte and halfword of a register is reachable at its own address.
// - Enable-protected registers ignore writes while the Control A enable bit is set.
// - Write-protected registers block writes while the access guard protects.
// - Synchronised writes take effect only after crossing to the core.
// - Control A resets to zero; enable-, write-protected and write-synchronised.
// - Busy flag rises at once, falls when done; repeat while busy errors.
// - Soft reset restores all but debug control and tx_char and disables; zero does nothing.
// - One to enable-set enables a source; one to enable-clear disables it.
// - Reserved bits of defined registers read back as zero.
`timescale 1ns/100ps

module urb_register_bank (
	input  wire logic                     clock,
	input  wire logic                     rst_b,
	input  wire urb_pkg::urb_bus_req_type bus_req,
	input  wire logic                     protect_on,
	input  wire logic [7:0]               irq_event,
	input  wire logic [7:0]               status_event,
	input  wire logic                     cts_level,
	input  wire logic [8:0]               rx_char,
	output logic      [31:0]              bus_rdata,
	output logic                          bus_error,
	output logic                          bus_done,
	output urb_pkg::urb_cfg_type          cfg,
	output logic                          unit_enabled,
	output logic                          irq_line,
	output logic      [8:0]               tx_char,
	output logic                          tx_char_valid,
	output logic                          rx_char_taken
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Byte lanes touched by an access; zero when misaligned
	function automatic logic [3:0] lanes(input logic [1:0] size,
		input logic [1:0] low);
		case (size)
			urb_pkg::SIZE_BYTE: lanes = 4'h1 << low;
			urb_pkg::SIZE_HALF: lanes = low[0] ? 4'h0 : (4'h3 << low);
			urb_pkg::SIZE_WORD: lanes = (low == 2'h0) ? 4'hF : 4'h0;
			default:            lanes = 4'h0;
		endcase
	endfunction

	// Merge written lanes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// Word index of an offset
	function automatic logic [3:0] word(input logic [5:0] off);
		word = off[5:2];
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [31:0] control_a, next_control_a;
	logic [31:0] control_b, next_control_b;
	logic [15:0] baud_divisor, next_baud_divisor;
	logic [7:0]  irda_min_pulse, next_irda_min_pulse;
	logic [7:0]  irq_enable, next_irq_enable;
	logic [7:0]  irq_flags, next_irq_flags;
	logic [7:0]  line_status, next_line_status;
	logic        halt_on_debug, next_halt_on_debug;
	urb_pkg::urb_cfg_type next_cfg;
	logic        next_unit_enabled, next_bus_error, next_irq_line;
	logic        next_tx_char_valid, next_rx_char_taken;
	logic [31:0] next_bus_rdata, tmp;
	logic [8:0]  next_tx_char;
	logic [2:0]  sync_start, sync_busy, sync_done;
	logic [3:0]  be;
	urb_sync_tracker #(
		.FLAGS  (urb_pkg::SYNC_FLAGS),
		.CYCLES (urb_pkg::SYNC_CYCLES)
	) tracker (
		.clock (clock),
		.rst_b (rst_b),
		.start (sync_start),
		.busy  (sync_busy),
		.done  (sync_done)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Bus decode, register writes, hardware flag sets, sync completion
	always_comb begin
		be                  = lanes(bus_req.size, bus_req.addr[1:0]);
		tmp                 = '0;
		next_control_a      = control_a;
		next_control_b      = control_b;
		next_baud_divisor   = baud_divisor;
		next_irda_min_pulse = irda_min_pulse;
		next_irq_enable     = irq_enable;
		next_irq_flags      = irq_flags;
		next_line_status    = line_status;
		next_halt_on_debug  = halt_on_debug;
		next_cfg            = cfg;
		next_unit_enabled   = unit_enabled;
		next_bus_rdata      = '0;
		next_bus_error      = 1'b0;
		next_tx_char        = tx_char;
		next_tx_char_valid  = 1'b0;
		next_rx_char_taken  = 1'b0;
		sync_start          = '0;
		if (bus_req.sel && be == 4'h0) begin
			next_bus_error = 1'b1;
		end else if (bus_req.sel && bus_req.write) begin
			case (bus_req.addr[5:2])
				word(urb_pkg::OFF_CONTROL_A): begin
					if (protect_on) begin
						next_bus_error = 1'b1;
					end else if (be[0] && (sync_busy[urb_pkg::SYNC_SOFT_RESET]
						|| sync_busy[urb_pkg::SYNC_ENABLE])) begin
						next_bus_error = 1'b1;
					end else begin
						tmp = merge(control_a, bus_req.wdata, be);
						if (control_a[urb_pkg::ENABLE_BIT]) begin
							tmp = (control_a & ~urb_pkg::CONTROL_A_LIVE)
								| (tmp & urb_pkg::CONTROL_A_LIVE);
						end
						next_control_a = tmp & urb_pkg::CONTROL_A_MASK;
						next_control_a[urb_pkg::SOFT_RESET_BIT] =
							control_a[urb_pkg::SOFT_RESET_BIT]
							| tmp[urb_pkg::SOFT_RESET_BIT];
						if (be[0]) begin
							sync_start[urb_pkg::SYNC_ENABLE] = 1'b1;
							sync_start[urb_pkg::SYNC_SOFT_RESET] =
								tmp[urb_pkg::SOFT_RESET_BIT];
						end
					end
				end
				word(urb_pkg::OFF_CONTROL_B): begin
					if (protect_on) begin
						next_bus_error = 1'b1;
					end else if (be[2] && sync_busy[urb_pkg::SYNC_CONTROL_B]) begin
						next_bus_error = 1'b1;
					end else begin
						tmp = merge(control_b, bus_req.wdata, be);
						if (control_a[urb_pkg::ENABLE_BIT]) begin
							tmp = (control_b & ~urb_pkg::CONTROL_B_LIVE)
								| (tmp & urb_pkg::CONTROL_B_LIVE);
						end
						next_control_b = tmp & urb_pkg::CONTROL_B_MASK;
						sync_start[urb_pkg::SYNC_CONTROL_B] = be[2];
					end
				end
				word(urb_pkg::OFF_BAUD_DIVISOR): begin
					if (protect_on) begin
						next_bus_error = 1'b1;
					end else if (!control_a[urb_pkg::ENABLE_BIT]) begin
						tmp = merge({8'h00, irda_min_pulse, baud_divisor},
							bus_req.wdata, be);
						next_baud_divisor   = tmp[15:0];
						next_irda_min_pulse =
							tmp[8*urb_pkg::OFF_IRDA_MIN_PULSE[1:0] +: 8];
					end
				end
				word(urb_pkg::OFF_IRQ_ENABLE_CLEAR): begin
					if (be[urb_pkg::OFF_IRQ_ENABLE_CLEAR[1:0]])
						next_irq_enable = next_irq_enable
							& ~bus_req.wdata[7:0];
					if (be[urb_pkg::OFF_IRQ_ENABLE_SET[1:0]])
						next_irq_enable = (next_irq_enable
							| bus_req.wdata[23:16]) & urb_pkg::IRQ_MASK;
				end
				word(urb_pkg::OFF_IRQ_FLAGS): begin
					if (be[urb_pkg::OFF_IRQ_FLAGS[1:0]])
						next_irq_flags = irq_flags & ~bus_req.wdata[7:0];
					if (be[urb_pkg::OFF_LINE_STATUS[1:0]])
						next_line_status = line_status & ~(bus_req.wdata[23:16]
							& urb_pkg::STATUS_W1C_MASK);
				end
				word(urb_pkg::OFF_CHAR_DATA): begin
					if (be[0]) begin
						next_tx_char       = {be[1] & bus_req.wdata[8],
							bus_req.wdata[7:0]};
						next_tx_char_valid = 1'b1;
					end
				end
				word(urb_pkg::OFF_DEBUG_CONTROL): begin
					if (protect_on)
						next_bus_error = 1'b1;
					else if (be[0])
						next_halt_on_debug = bus_req.wdata[0];
				end
				default: ;
			endcase
		end else if (bus_req.sel) begin
			case (bus_req.addr[5:2])
				word(urb_pkg::OFF_CONTROL_A):
					next_bus_rdata = control_a;
				word(urb_pkg::OFF_CONTROL_B):
					next_bus_rdata = control_b;
				word(urb_pkg::OFF_BAUD_DIVISOR):
					next_bus_rdata = {8'h00, irda_min_pulse, baud_divisor};
				word(urb_pkg::OFF_IRQ_ENABLE_CLEAR):
					next_bus_rdata = {8'h00, irq_enable, 8'h00, irq_enable};
				word(urb_pkg::OFF_IRQ_FLAGS): begin
					tmp = {24'h000000, line_status};
					tmp[urb_pkg::CTS_BIT] = cts_level;
					next_bus_rdata = {tmp[15:0], 8'h00, irq_flags};
				end
				word(urb_pkg::OFF_SYNC_PENDING):
					next_bus_rdata = {29'h00000000, sync_busy};
				word(urb_pkg::OFF_CHAR_DATA): begin
					next_bus_rdata     = {23'h000000, rx_char};
					next_rx_char_taken = be[0];
				end
				word(urb_pkg::OFF_DEBUG_CONTROL):
					next_bus_rdata = {31'h00000000, halt_on_debug};
				default: next_bus_rdata = '0;
			endcase
			next_bus_rdata = next_bus_rdata & merge('0, 32'hFFFFFFFF, be);
		end
		// Hardware events set after software clears, so set wins
		next_irq_flags   = (next_irq_flags | irq_event) & urb_pkg::IRQ_MASK;
		next_line_status = (next_line_status | status_event)
			& urb_pkg::STATUS_W1C_MASK;
		// Synchronised values reach the core only when settled
		if (sync_done[urb_pkg::SYNC_ENABLE])
			next_unit_enabled = control_a[urb_pkg::ENABLE_BIT];
		if (sync_done[urb_pkg::SYNC_CONTROL_B])
			next_cfg.control_b = control_b;
		next_cfg.control_a      = control_a;
		next_cfg.baud_divisor   = baud_divisor;
		next_cfg.irda_min_pulse = irda_min_pulse;
		next_cfg.halt_on_debug  = halt_on_debug;
		if (sync_done[urb_pkg::SYNC_SOFT_RESET]) begin
			next_control_a      = urb_pkg::CONTROL_A_RESET;
			next_control_b      = urb_pkg::CONTROL_B_RESET;
			next_baud_divisor   = urb_pkg::BAUD_RESET;
			next_irda_min_pulse = urb_pkg::PULSE_RESET;
			next_irq_enable     = '0;
			next_irq_flags      = '0;
			next_line_status    = '0;
			next_unit_enabled   = 1'b0;
			next_cfg.control_b  = urb_pkg::CONTROL_B_RESET;
		end
		next_irq_line = |(next_irq_flags & next_irq_enable);
	end

	// Register stage
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			control_a      <= urb_pkg::CONTROL_A_RESET;
			control_b      <= urb_pkg::CONTROL_B_RESET;
			baud_divisor   <= urb_pkg::BAUD_RESET;
			irda_min_pulse <= urb_pkg::PULSE_RESET;
			irq_enable     <= '0;
			irq_flags      <= '0;
			line_status    <= '0;
			halt_on_debug  <= 1'b0;
			cfg            <= '0;
			unit_enabled   <= 1'b0;
			bus_rdata      <= '0;
			bus_error      <= 1'b0;
			bus_done       <= 1'b0;
			irq_line       <= 1'b0;
			tx_char        <= urb_pkg::CHAR_RESET;
			tx_char_valid  <= 1'b0;
			rx_char_taken  <= 1'b0;
		end else begin
			control_a      <= next_control_a;
			control_b      <= next_control_b;
			baud_divisor   <= next_baud_divisor;
			irda_min_pulse <= next_irda_min_pulse;
			irq_enable     <= next_irq_enable;
			irq_flags      <= next_irq_flags;
			line_status    <= next_line_status;
			halt_on_debug  <= next_halt_on_debug;
			cfg            <= next_cfg;
			unit_enabled   <= next_unit_enabled;
			bus_rdata      <= next_bus_rdata;
			bus_error      <= next_bus_error;
			bus_done       <= bus_req.sel;
			irq_line       <= next_irq_line;
			tx_char        <= next_tx_char;
			tx_char_valid  <= next_tx_char_valid;
			rx_char_taken  <= next_rx_char_taken;
		end
	end

endmodule

// >>> urb_register_bank_assertions.sv
/*
 * Checker of the serial unit register bank bus answers and protections.
 * Assumes it is bound to urb_register_bank and sees only its ports.
 */
`timescale 1ns/100ps

module urb_checker (
	input wire logic                     clock,
	input wire logic                     rst_b,
	input wire urb_pkg::urb_bus_req_type bus_req,
	input wire logic                     protect_on,
	input wire logic [31:0]              bus_rdata,
	input wire logic                     bus_error,
	input wire logic                     bus_done,
	input wire urb_pkg::urb_cfg_type     cfg,
	input wire logic                     unit_enabled,
	input wire logic                     irq_line,
	input wire logic                     rx_char_taken
);
	// ------------------------------------------------------------------
	// Bus answer checks
	// ------------------------------------------------------------------
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_done_follows: assert property (bus_req.sel |=> bus_done)
		else $error("no answer after request");
	a_no_stray_done: assert property (!bus_req.sel |=> !bus_done)
		else $error("answer without request");
	a_error_with_done: assert property (bus_error |-> bus_done)
		else $error("error outside answer");
	a_misaligned_error: assert property (bus_req.sel &&
		(bus_req.size == 2'h3 || (bus_req.size == urb_pkg::SIZE_HALF
		&& bus_req.addr[0]) || (bus_req.size == urb_pkg::SIZE_WORD
		&& bus_req.addr[1:0] != 2'h0)) |=> bus_error)
		else $error("misaligned access not refused");
	a_guard_blocks: assert property (bus_req.sel && bus_req.write
		&& protect_on && bus_req.addr == urb_pkg::OFF_CONTROL_B
		&& bus_req.size == urb_pkg::SIZE_WORD |=> bus_error)
		else $error("protected write not refused");
	a_hole_reads_zero: assert property (bus_req.sel && !bus_req.write
		&& bus_req.addr[5:2] == 4'h2 && bus_req.size == urb_pkg::SIZE_BYTE
		|=> bus_rdata == 32'h00000000 && !bus_error)
		else $error("reserved offset not zero");
	a_reserved_bits: assert property (bus_req.sel && !bus_req.write
		&& bus_req.addr == urb_pkg::OFF_CONTROL_A
		&& bus_req.size == urb_pkg::SIZE_WORD
		|=> (bus_rdata & ~urb_pkg::CONTROL_A_MASK) == 32'h00000000)
		else $error("reserved bits not zero");
	a_enable_synced: assert property ($rose(unit_enabled)
		|-> cfg.control_a[urb_pkg::ENABLE_BIT])
		else $error("enabled without stored enable");
	a_reset_quiet: assert property ($rose(rst_b) |-> cfg == '0
		&& !unit_enabled && !bus_done && !irq_line)
		else $error("outputs not cleared by reset");
	a_char_taken: assert property (bus_req.sel && !bus_req.write
		&& bus_req.addr == urb_pkg::OFF_CHAR_DATA
		&& bus_req.size == urb_pkg::SIZE_HALF |=> rx_char_taken)
		else $error("character read not signalled");

	// Main scenarios reached
	c_write: cover property (bus_req.sel && bus_req.write);
	c_error: cover property (bus_error);
	c_enable: cover property ($rose(unit_enabled));
	c_irq: cover property ($rose(irq_line));
endmodule

bind urb_register_bank urb_checker urb_checker_inst (
	.clock         (clock),
	.rst_b         (rst_b),
	.bus_req       (bus_req),
	.protect_on    (protect_on),
	.bus_rdata     (bus_rdata),
	.bus_error     (bus_error),
	.bus_done      (bus_done),
	.cfg           (cfg),
	.unit_enabled  (unit_enabled),
	.irq_line      (irq_line),
	.rx_char_taken (rx_char_taken)
);

// >>> urb_sync_tracker.sv
/*
 * Tracks each synchronised operation: its busy flag rises the cycle after
 * the start pulse and falls after a fixed settling time, with a one-cycle
 * done pulse. Assumes start pulses come only while the flag is clear.
 */
`timescale 1ns/100ps

module urb_sync_tracker #(
	parameter int FLAGS  = urb_pkg::SYNC_FLAGS,
	parameter int CYCLES = urb_pkg::SYNC_CYCLES
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic [FLAGS-1:0] start,
	output logic      [FLAGS-1:0] busy,
	output logic      [FLAGS-1:0] done
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0]    count      [FLAGS];
	logic [CW-1:0]    next_count [FLAGS];
	logic [FLAGS-1:0] next_busy;
	logic [FLAGS-1:0] next_done;

	// ------------------------------------------------------------------
	// Settling counters
	// ------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < FLAGS; i++) begin
			next_count[i] = count[i];
			next_busy[i]  = busy[i];
			next_done[i]  = 1'b0;
			if (start[i]) begin
				next_busy[i]  = 1'b1;
				next_count[i] = '0;
			end else if (busy[i]) begin
				if (count[i] == LAST) begin
					next_busy[i] = 1'b0;
					next_done[i] = 1'b1;
				end else begin
					next_count[i] = count[i] + CW'(1);
				end
			end
		end
	end

	// Register stage
	always_ff @(posedge clock) begin
		for (int i = 0; i < FLAGS; i++) begin
			count[i] <= rst_b ? next_count[i] : '0;
		end
		busy <= rst_b ? next_busy : '0;
		done <= rst_b ? next_done : '0;
	end

endmodule
